//--- rtl/ubpc_map.svh
/*
 Offsets, field positions, reset values and packet size figures
 for the bulk pipe configuration and control block.
 Assumes byte addresses on an 8-bit register address port.
*/
`ifndef UBPC_MAP_SVH
`define UBPC_MAP_SVH
`define UBPC_SEL_ADDR  8'h8E
`define UBPC_WIN_ADDR  8'h90
`define UBPC_CTL1_ADDR 8'hA0
`define UBPC_CTL2_ADDR 8'hA2
`define UBPC_CTL3_ADDR 8'hA4
`define UBPC_CTL4_ADDR 8'hA6
`define UBPC_CTL_BASE  5'h14
`define UBPC_B_RDYIRQ  10
`define UBPC_B_DBL_BUF 9
`define UBPC_B_CONT    8
`define UBPC_B_DIR     4
`define UBPC_B_ACCESS  15
`define UBPC_B_FLUSH   9
`define UBPC_B_TOG_RST 8
`define UBPC_B_NYET    4
`define UBPC_RST16     16'h0000
`define UBPC_FS_MPS    11'h040
`define UBPC_HS_MPS    11'h200
`define UBPC_CONT_TOT  11'h200
`endif

//--- rtl/ubpc_pkg.sv
/*
 Types shared by the bulk pipe configuration block.
 Assumes ubpc_map.svh carries the numeric constants.
*/
package ubpc_pkg;
	typedef struct packed {
		logic irq_mode;
		logic dbl_buf;
		logic cont_mode;
		logic dir;
	} ubpc_cfg_t;
	typedef struct packed {
		logic       flush;
		logic       nyet;
		logic [1:0] pid;
	} ubpc_ctl_t;
	typedef enum logic [2:0] {
		UBPC_HS_NAK   = 3'h0,
		UBPC_HS_ACK   = 3'h1,
		UBPC_HS_NYET  = 3'h2,
		UBPC_HS_STALL = 3'h3,
		UBPC_HS_DATA  = 3'h4
	} ubpc_hs_t;
endpackage

//--- rtl/ubpc_top.sv
/*
 Bulk pipe configuration window and pipe 1-4 control registers,
 with handshake choice, completion counting and data toggles.
 Assumes a single-cycle register master and a SIE that sends
 one token, one packet end and one CPU byte per cycle at most.
*/
// Our own choice: the plain strobed port.
// Contract
// (R1) Ready-irq mode bit on OUT pipe: 0 CPU, 1 DMA.
// (R2) Irq mode and continuous bits only for pipes 1-4.
// (R3) Double-buffer bit only for pipes 1 and 2.
// (R4) Software sets NAK before changing any pipe configuration.
// (R5) FS non-continuous: IN/OUT done at 64 bytes or short packet.
// (R6) FS non-continuous CPU write done at 64 bytes or commit.
// (R7) FS continuous IN done at 512 total or short packet.
// (R8) FS continuous CPU write done at 512 bytes or commit.
// (R9) FS continuous OUT done at 512, short, or count target.
// (R10) Hi-speed: continuous bit set, completion at 512 or short.
// (R11) Software clears the buffer after direction change.
// (R12) Endpoint id reads selected pipe number, writes ignored.
// (R13) PID 00 NAK, 01 buffer dependent, 1x STALL.
// (R14) Buffer access flag reads 1 when CPU may access.
// (R15) Flush bit clears buffers, stays until software clears.
// (R16) Flush on OUT BUF pipe: ACK and discard data.
// (R17) IN flush sequence: NAK, flush on, flush off, BUF.
// (R18) Toggle reset write 1 gives DATA0; reads always 0.
// (R19) USB bus reset leaves toggles; software resets them.
// (R20) Toggle resets of different pipes spaced 200 ns.
// (R21) NYET policy only for hi-speed bulk OUT BUF.
// (R22) Auto NYET: full NAK, space twice MPS ACK, else NYET.
// (R23) ACK-only policy never answers NYET.
`timescale 1ns/1ps
`include "ubpc_map.svh"
`default_nettype none
module ubpc_top (
	input  wire logic                      core_clk,
	input  wire logic                      rst_b,
	input  wire logic [7:0]                reg_addr,
	input  wire logic [15:0]               reg_wdata,
	input  wire logic                      reg_wr,
	input  wire logic                      reg_rd,
	output logic      [15:0]               reg_rdata,
	input  wire logic                      usb_bus_rst,
	input  wire logic                      hs_mode,
	input  wire logic                      tok_vld,
	input  wire logic [2:0]                tok_pipe,
	input  wire logic                      rx_buf_full,
	input  wire logic                      rx_space_2x,
	input  wire logic                      tx_buf_rdy,
	output logic                           hs_vld,
	output ubpc_pkg::ubpc_hs_t             hs_code,
	output logic                           hs_toggle,
	output logic                           hs_discard,
	input  wire logic [3:0]                tog_adv,
	input  wire logic                      pkt_end,
	input  wire logic [2:0]                pkt_pipe,
	input  wire logic [10:0]               pkt_len,
	input  wire logic [15:0]               transfer_count_target,
	output logic                           xfer_done,
	output logic      [2:0]                xfer_pipe,
	input  wire logic                      cpu_wr_byte,
	input  wire logic                      buffer_valid_commit,
	input  wire logic [2:0]                cpu_pipe,
	output logic                           cpu_wr_done,
	output logic      [2:0]                cpu_done_pipe,
	input  wire logic [3:0]                buf_cpu_ok,
	output ubpc_pkg::ubpc_cfg_t [3:0]      pipe_cfg,
	output logic      [3:0]                buffer_flush_ctl,
	output logic      [3:0]                ready_irq_dma
);
	// Pipe number 1-4 to array slot
	function automatic logic [1:0] pidx(input logic [2:0] p);
		logic [2:0] d;
		d = p - 3'h1;
		return d[1:0];
	endfunction
	function automatic logic bulk(input logic [2:0] p);
		return (p >= 3'h1) && (p <= 3'h4);
	endfunction

	logic                      [2:0]  sel_r;
	ubpc_pkg::ubpc_cfg_t       [3:0]  cfg_r;
	ubpc_pkg::ubpc_ctl_t       [3:0]  ctl_r;
	logic                      [3:0]  tog_r;
	logic                      [3:0]  access_r;
	logic                      [10:0] acc_r [4];
	logic                      [15:0] cnt_r [4];
	logic                      [10:0] wacc_r [4];
	logic                      [15:0] rd_r;
	logic                             hv_r;
	ubpc_pkg::ubpc_hs_t               hc_r;
	logic                             ht_r;
	logic                             hd_r;
	logic                             xd_r;
	logic                      [2:0]  xp_r;
	logic                             cd_r;
	logic                      [2:0]  cp_r;
	logic                      [3:0]  dma_r;

	logic                             win_wr;
	logic                             ctl_hit;
	logic                      [1:0]  ci;
	assign win_wr  = reg_wr && (reg_addr == `UBPC_WIN_ADDR);
	assign ctl_hit = (reg_addr[7:3] == `UBPC_CTL_BASE) && !reg_addr[0];
	assign ci      = reg_addr[2:1];

	// Pipe select for the configuration window
	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			sel_r <= 3'h0;
		end else if (reg_wr && reg_addr == `UBPC_SEL_ADDR) begin
			sel_r <= reg_wdata[2:0];
		end
	end

	// Window writes land only where the pipe has the option
	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			cfg_r <= '0;
		end else if (win_wr && bulk(sel_r)) begin // [R2]
			cfg_r[pidx(sel_r)].irq_mode  <= reg_wdata[`UBPC_B_RDYIRQ];
			cfg_r[pidx(sel_r)].cont_mode <= reg_wdata[`UBPC_B_CONT];
			cfg_r[pidx(sel_r)].dir       <= reg_wdata[`UBPC_B_DIR];
			if (sel_r <= 3'h2) begin // [R3]
				cfg_r[pidx(sel_r)].dbl_buf <= reg_wdata[`UBPC_B_DBL_BUF];
			end
		end
	end

	// Buffer-ready interrupt flavour, meaningful on OUT only
	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			dma_r <= 4'h0;
		end else begin
			for (int i = 0; i < 4; i++) begin
				dma_r[i] <= cfg_r[i].irq_mode & ~cfg_r[i].dir; // [R1]
			end
		end
	end

	// Oversize OUT packet forces STALL; it wins over software
	logic                      [1:0]  pp;
	logic                      [10:0] mps;
	logic                             ovs;
	assign pp  = pidx(pkt_pipe);
	assign mps = hs_mode ? `UBPC_HS_MPS : `UBPC_FS_MPS;
	assign ovs = pkt_end && bulk(pkt_pipe) && !cfg_r[pp].dir && (pkt_len > mps);

	// Control registers; bus reset drops PID to NAK
	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			ctl_r <= '0;
		end else begin
			for (int i = 0; i < 4; i++) begin
				if (reg_wr && ctl_hit && ci == 2'(i)) begin
					ctl_r[i].flush <= reg_wdata[`UBPC_B_FLUSH]; // [R15]
					ctl_r[i].nyet <= reg_wdata[`UBPC_B_NYET];
					ctl_r[i].pid  <= reg_wdata[1:0];
				end
				if (usb_bus_rst) begin
					ctl_r[i].pid <= 2'h0;
				end
				if (ovs && pp == 2'(i)) begin
					ctl_r[i].pid[1] <= 1'b1;
				end
			end
		end
	end

	// Toggles survive bus reset; software reset beats an advance
	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			tog_r <= 4'h0;
		end else begin
			for (int i = 0; i < 4; i++) begin
				if (reg_wr && ctl_hit && ci == 2'(i) && reg_wdata[`UBPC_B_TOG_RST]) begin
					tog_r[i] <= 1'b0; // [R18] [R19]
				end else if (tog_adv[i]) begin
					tog_r[i] <= ~tog_r[i];
				end
			end
		end
	end

	// Sampled buffer access status for readback
	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			access_r <= 4'h0;
		end else begin
			access_r <= buf_cpu_ok; // [R14]
		end
	end

	// Read data stand one cycle, zero otherwise
	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			rd_r <= `UBPC_RST16;
		end else begin
			rd_r <= `UBPC_RST16;
			if (reg_rd && reg_addr == `UBPC_SEL_ADDR) begin
				rd_r[2:0] <= sel_r;
			end else if (reg_rd && reg_addr == `UBPC_WIN_ADDR) begin
				if (sel_r != 3'h7) begin
					rd_r[2:0] <= sel_r; // [R12]
				end
				if (bulk(sel_r)) begin
					rd_r[`UBPC_B_RDYIRQ]  <= cfg_r[pidx(sel_r)].irq_mode;
					rd_r[`UBPC_B_DBL_BUF] <= cfg_r[pidx(sel_r)].dbl_buf;
					rd_r[`UBPC_B_CONT]    <= cfg_r[pidx(sel_r)].cont_mode;
					rd_r[`UBPC_B_DIR]   <= cfg_r[pidx(sel_r)].dir;
				end
			end else if (reg_rd && ctl_hit) begin
				rd_r[`UBPC_B_ACCESS] <= access_r[ci]; // [R14]
				rd_r[`UBPC_B_FLUSH]  <= ctl_r[ci].flush;
				rd_r[`UBPC_B_NYET] <= ctl_r[ci].nyet;
				rd_r[1:0]          <= ctl_r[ci].pid;
			end
		end
	end

	// Handshake choice for a token on a bulk pipe
	logic                      [1:0]  tp;
	ubpc_pkg::ubpc_ctl_t              tc;
	logic                             tout;
	ubpc_pkg::ubpc_hs_t               hnx;
	assign tp   = pidx(tok_pipe);
	assign tc   = ctl_r[tp];
	assign tout = !cfg_r[tp].dir;
	always_comb begin
		hnx = ubpc_pkg::UBPC_HS_NAK; // [R13]
		if (tc.pid[1]) begin
			hnx = ubpc_pkg::UBPC_HS_STALL; // [R13]
		end else if (tc.pid[0] && !tout) begin
			hnx = tx_buf_rdy ? ubpc_pkg::UBPC_HS_DATA : ubpc_pkg::UBPC_HS_NAK;
		end else if (tc.pid[0] && tc.flush) begin
			hnx = ubpc_pkg::UBPC_HS_ACK; // [R16]
		end else if (tc.pid[0] && rx_buf_full) begin
			hnx = ubpc_pkg::UBPC_HS_NAK; // [R22] [R23]
		end else if (tc.pid[0] && hs_mode && !tc.nyet && !rx_space_2x) begin
			hnx = ubpc_pkg::UBPC_HS_NYET; // [R21] [R22]
		end else if (tc.pid[0]) begin
			hnx = ubpc_pkg::UBPC_HS_ACK; // [R23]
		end
	end

	// Answer register; tokens for pipes 5-6 get no answer here
	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			hv_r <= 1'b0;
			hc_r <= ubpc_pkg::UBPC_HS_NAK;
			ht_r <= 1'b0;
			hd_r <= 1'b0;
		end else begin
			hv_r <= tok_vld && bulk(tok_pipe);
			hc_r <= hnx;
			ht_r <= tog_r[tp];
			hd_r <= tok_vld && bulk(tok_pipe) && tout && (tc.pid == 2'h1) && tc.flush; // [R16]
		end
	end

	// Packet completion; continuous mode exists only at full speed
	logic                             cont;
	logic                      [10:0] sum;
	logic                      [15:0] cn1;
	logic                             pdone;
	assign cont  = cfg_r[pp].cont_mode && !hs_mode; // [R10]
	assign sum   = acc_r[pp] + pkt_len;
	assign cn1   = cnt_r[pp] + 16'h0001;
	assign pdone = !cont || (pkt_len < mps) || (sum >= `UBPC_CONT_TOT) ||
		(!cfg_r[pp].dir && cn1 == transfer_count_target); // [R5] [R7] [R9]

	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			for (int i = 0; i < 4; i++) begin
				acc_r[i] <= 11'h000;
				cnt_r[i] <= 16'h0000;
			end
		end else begin
			for (int i = 0; i < 4; i++) begin
				if (ctl_r[i].flush || (pkt_end && bulk(pkt_pipe) && pp == 2'(i) && pdone)) begin
					acc_r[i] <= 11'h000; // [R15]
					cnt_r[i] <= 16'h0000;
				end else if (pkt_end && bulk(pkt_pipe) && pp == 2'(i)) begin
					acc_r[i] <= sum;
					cnt_r[i] <= cn1;
				end
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			xd_r <= 1'b0;
			xp_r <= 3'h0;
		end else begin
			xd_r <= pkt_end && bulk(pkt_pipe) && pdone;
			xp_r <= pkt_pipe;
		end
	end

	// CPU write completion; hi-speed uses the 512-byte limit whether or not the continuous bit is set
	logic                      [1:0]  cw;
	logic                      [10:0] wlim;
	logic                      [10:0] ws;
	logic                             wdone;
	logic                             cvld;
	assign cw    = pidx(cpu_pipe);
	assign cvld  = bulk(cpu_pipe) && cfg_r[cw].dir;
	assign wlim  = (hs_mode || cfg_r[cw].cont_mode) ? `UBPC_CONT_TOT : `UBPC_FS_MPS; // [R10]
	assign ws    = wacc_r[cw] + 11'h001;
	assign wdone = cvld && (buffer_valid_commit || (cpu_wr_byte && ws == wlim)); // [R6] [R8]

	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			for (int i = 0; i < 4; i++) begin
				wacc_r[i] <= 11'h000;
			end
		end else begin
			for (int i = 0; i < 4; i++) begin
				if (ctl_r[i].flush || (wdone && cw == 2'(i))) begin
					wacc_r[i] <= 11'h000;
				end else if (cvld && cpu_wr_byte && cw == 2'(i)) begin
					wacc_r[i] <= ws;
				end
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			cd_r <= 1'b0;
			cp_r <= 3'h0;
		end else begin
			cd_r <= wdone;
			cp_r <= cpu_pipe;
		end
	end

	assign reg_rdata        = rd_r;
	assign hs_vld           = hv_r;
	assign hs_code          = hc_r;
	assign hs_toggle        = ht_r;
	assign hs_discard       = hd_r;
	assign xfer_done        = xd_r;
	assign xfer_pipe        = xp_r;
	assign cpu_wr_done      = cd_r;
	assign cpu_done_pipe    = cp_r;
	assign pipe_cfg         = cfg_r;
	assign buffer_flush_ctl = {ctl_r[3].flush, ctl_r[2].flush, ctl_r[1].flush, ctl_r[0].flush};
	assign ready_irq_dma    = dma_r;

	// Checks on the design's own answers
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_b);
	sequence s_buf_out;
		tok_vld && bulk(tok_pipe) && tout && tc.pid == 2'h1 && !tc.flush;
	endsequence
	property p_nak;
		tok_vld && bulk(tok_pipe) && tc.pid == 2'h0 |=> hs_vld && hs_code == ubpc_pkg::UBPC_HS_NAK;
	endproperty
	a_nak: assert property (p_nak) else $error("pid 00 not NAK"); // [R13]
	property p_stall;
		tok_vld && bulk(tok_pipe) && tc.pid[1] |=> hs_code == ubpc_pkg::UBPC_HS_STALL;
	endproperty
	a_stall: assert property (p_stall) else $error("pid 1x not STALL"); // [R13]
	property p_flush;
		tok_vld && bulk(tok_pipe) && tout && tc.pid == 2'h1 && tc.flush |=>
			hs_code == ubpc_pkg::UBPC_HS_ACK && hs_discard;
	endproperty
	a_flush: assert property (p_flush) else $error("flush OUT not ACK+discard"); // [R16]
	property p_nyet;
		s_buf_out ##0 (hs_mode && !tc.nyet && !rx_buf_full && !rx_space_2x) |=>
			hs_code == ubpc_pkg::UBPC_HS_NYET;
	endproperty
	a_nyet: assert property (p_nyet) else $error("missing NYET"); // [R22]
	property p_acko;
		s_buf_out ##0 tc.nyet |=> hs_code != ubpc_pkg::UBPC_HS_NYET;
	endproperty
	a_acko: assert property (p_acko) else $error("NYET in ACK-only"); // [R23]
	property p_fsnyet;
		s_buf_out ##0 !hs_mode |=> hs_code != ubpc_pkg::UBPC_HS_NYET;
	endproperty
	a_fsnyet: assert property (p_fsnyet) else $error("NYET at full speed"); // [R21]
	property p_sqrd;
		reg_rd && ctl_hit |=> !reg_rdata[`UBPC_B_TOG_RST] ##1 reg_rdata == 16'h0000 || $past(reg_rd);
	endproperty
	a_sqrd: assert property (p_sqrd) else $error("toggle reset bit read 1"); // [R18]
	property p_ep;
		reg_rd && reg_addr == `UBPC_WIN_ADDR && sel_r != 3'h7 |=> reg_rdata[2:0] == $past(sel_r);
	endproperty
	a_ep: assert property (p_ep) else $error("endpoint id wrong"); // [R12]
	property p_p56;
		win_wr && !bulk(sel_r) |=> $stable(cfg_r);
	endproperty
	a_p56: assert property (p_p56) else $error("pipe 5/6 write took effect"); // [R2]
	property p_double_buffer_sel;
		cfg_r[2].dbl_buf == 1'b0 && cfg_r[3].dbl_buf == 1'b0;
	endproperty
	a_double_buffer_sel: assert property (p_double_buffer_sel) else $error("single pipe has double buffer"); // [R3]
	property p_commit;
		buffer_valid_commit && cvld |=> cpu_wr_done && cpu_done_pipe == $past(cpu_pipe);
	endproperty
	a_commit: assert property (p_commit) else $error("commit did not complete"); // [R6]
endmodule
`default_nettype wire

//--- verif/ubpc_host_model.sv
/*
 Behavioural USB host facing the bulk pipe block: sends tokens and
 packet ends when the bench asks for them.
 Assumes the block answers a token exactly one cycle after taking it.
*/
`timescale 1ns/1ps
`default_nettype none
module ubpc_host_model (
	input  wire logic               core_clk,
	output logic                    tok_vld,
	output logic [2:0]              tok_pipe,
	output logic                    pkt_end,
	output logic [2:0]              pkt_pipe,
	output logic [10:0]             pkt_len,
	input  wire logic               hs_vld,
	input  wire ubpc_pkg::ubpc_hs_t hs_code
);
	// Quiet bus at start
	initial begin
		tok_vld = 1'b0;
		tok_pipe = 3'h0;
		pkt_end = 1'b0;
		pkt_pipe = 3'h0;
		pkt_len = 11'h000;
	end
	// One token; released lines show the inverse so stale values never match
	task automatic token(input logic [2:0] p, output logic v, output ubpc_pkg::ubpc_hs_t c);
		@(posedge core_clk);
		tok_vld <= 1'b1;
		tok_pipe <= p;
		@(posedge core_clk);
		tok_vld <= 1'b0;
		tok_pipe <= ~p;
		#1;
		v = hs_vld;
		c = hs_code;
	endtask
	// End of one data packet of n bytes; short or empty ones end a transfer
	task automatic packet(input logic [2:0] p, input logic [10:0] n);
		@(posedge core_clk);
		pkt_end <= 1'b1;
		pkt_pipe <= p;
		pkt_len <= n;
		@(posedge core_clk);
		pkt_end <= 1'b0;
		pkt_pipe <= ~p;
		pkt_len <= ~n;
		#1;
	endtask
endmodule
`default_nettype wire

//--- verif/tb_usb_bulk_pipe_config_control.sv
/*
 Self-checking bench for the bulk pipe configuration block.
 Assumes ubpc_top and ubpc_host_model are compiled before it.
*/
`timescale 1ns/1ps
`include "ubpc_map.svh"
`default_nettype none
module tb_usb_bulk_pipe_config_control;
	logic                      core_clk, rst_b, reg_wr, reg_rd, usb_bus_rst, hs_mode, v;
	logic                      rx_buf_full, rx_space_2x, tx_buf_rdy, hs_vld, hs_toggle;
	logic                      hs_discard, pkt_end, xfer_done, cpu_wr_byte, tok_vld;
	logic                      buffer_valid_commit, cpu_wr_done;
	logic [2:0]                tok_pipe, pkt_pipe, xfer_pipe, cpu_pipe, cpu_done_pipe;
	logic [3:0]                tog_adv, buf_cpu_ok, buffer_flush_ctl, ready_irq_dma;
	logic [7:0]                reg_addr;
	logic [10:0]               pkt_len;
	logic [15:0]               reg_wdata, reg_rdata, transfer_count_target;
	int                        n_fail, n_checks, k;
	ubpc_pkg::ubpc_hs_t        hs_code, c;
	ubpc_pkg::ubpc_cfg_t [3:0] pipe_cfg;
	// Handshake table rows; codes 0 NAK 1 ACK 2 NYET 3 STALL 4 DATA
	logic [15:0]               cfgw [4] = '{16'h0400, 16'h0010, 16'h0100, 16'h0510};
	logic [15:0]               hctl [9] = '{16'h0001, 16'h0001, 16'h0001, 16'h0001,
		16'h0011, 16'h0201, 16'h0000, 16'h0002, 16'h0003};
	logic [2:0]                hexp [9] = '{3'h1, 3'h2, 3'h1, 3'h0, 3'h1, 3'h1, 3'h0, 3'h3, 3'h3};
	logic [8:0]                hsm = 9'b111111110;
	logic [8:0]                spc = 9'b000001100;
	logic [8:0]                ful = 9'b000001000;
	logic [8:0]                dsc = 9'b000100000;

	ubpc_top ubpc_top_inst (.core_clk, .rst_b, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
		.reg_rdata, .usb_bus_rst, .hs_mode, .tok_vld, .tok_pipe, .rx_buf_full, .rx_space_2x,
		.tx_buf_rdy, .hs_vld, .hs_code, .hs_toggle, .hs_discard, .tog_adv, .pkt_end, .pkt_pipe,
		.pkt_len, .transfer_count_target, .xfer_done, .xfer_pipe, .cpu_wr_byte,
		.buffer_valid_commit, .cpu_pipe, .cpu_wr_done, .cpu_done_pipe, .buf_cpu_ok, .pipe_cfg,
		.buffer_flush_ctl, .ready_irq_dma);
	ubpc_host_model ubpc_host_model_inst (.core_clk, .tok_vld, .tok_pipe, .pkt_end, .pkt_pipe,
		.pkt_len, .hs_vld, .hs_code);

	// 100 MHz clock
	initial begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end
	// Hang guard, well past the longest run
	initial begin
		#500000;
		n_fail++;
		print_verdict();
	end

	task automatic print_verdict();
		$display("checks %0d mismatches %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		n_checks++;
		if (seen !== exp) begin
			n_fail++;
			$display("FAIL t=%0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	// Single-cycle register strobes, released after the taking edge
	task automatic wr(input logic [7:0] a, input logic [15:0] w);
		@(posedge core_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= w;
		@(posedge core_clk);
		reg_wr <= 1'b0;
		reg_wdata <= ~w;
	endtask
	task automatic rchk(input logic [7:0] a, input logic [15:0] e);
		@(posedge core_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		#1;
		chk(reg_rdata, e);
	endtask
	// One CPU byte, or a commit when cm is set
	task automatic cpu(input logic [2:0] p, input logic cm);
		@(posedge core_clk);
		cpu_wr_byte <= ~cm;
		buffer_valid_commit <= cm;
		cpu_pipe <= p;
		@(posedge core_clk);
		cpu_wr_byte <= 1'b0;
		buffer_valid_commit <= 1'b0;
		#1;
		v = cpu_wr_done;
	endtask
	// Only the last step of a CPU write may complete it
	task automatic cw(input logic [2:0] p, input int n, input logic cm);
		int s;
		s = 0;
		for (int i = 1; i < n + int'(cm); i++) begin
			cpu(p, 1'b0);
			s += int'(v);
		end
		cpu(p, cm);
		chk({v, cpu_done_pipe, 12'(s)}, {1'b1, p, 12'h000});
	endtask
	task automatic pk(input logic [2:0] p, input logic [10:0] n, input logic e);
		ubpc_host_model_inst.packet(p, n);
		chk(16'({xfer_done, (e ? xfer_pipe : p)}), 16'({e, p}));
	endtask

	initial begin
		{rst_b, reg_wr, reg_rd, usb_bus_rst, hs_mode, rx_buf_full, rx_space_2x} = '0;
		{tx_buf_rdy, cpu_wr_byte, buffer_valid_commit, tog_adv, buf_cpu_ok, cpu_pipe} = '0;
		{reg_addr, reg_wdata} = '0;
		transfer_count_target = 16'hFFFF;
		n_fail = 0;
		n_checks = 0;
		repeat (16) @(posedge core_clk);
		rst_b <= 1'b1;
		for (k = 0; k < 4; k++) rchk(`UBPC_CTL1_ADDR + 8'(2 * k), 16'h0000);
		wr(8'h12, 16'hFFFF);
		rchk(8'h12, 16'h0000);
		// Select values 1 to 7, all writable bits set
		for (k = 1; k <= 7; k++) begin
			wr(`UBPC_SEL_ADDR, 16'(k));
			wr(`UBPC_WIN_ADDR, 16'h0717);
			rchk(`UBPC_WIN_ADDR, (k <= 4 ? 16'h0510 : 16'h0000) | (k <= 2 ? 16'h0200 : 16'h0000)
				| (k <= 6 ? 16'(k) : 16'h0000));
		end
		chk(16'(pipe_cfg), 16'hBBFF);
		for (k = 0; k < 4; k++) begin
			wr(`UBPC_SEL_ADDR, 16'(k + 1));
			wr(`UBPC_WIN_ADDR, cfgw[k]);
		end
		// Buffers cleared after the direction changes: NAK, flush on, flush off, BUF
		for (k = 0; k < 4; k++) begin
			wr(`UBPC_CTL1_ADDR + 8'(2 * k), 16'h0000);
			wr(`UBPC_CTL1_ADDR + 8'(2 * k), 16'h0200);
			#1;
			chk(16'(buffer_flush_ctl), 16'(1 << k));
			wr(`UBPC_CTL1_ADDR + 8'(2 * k), 16'h0000);
			#1;
			chk(16'(buffer_flush_ctl), 16'h0000);
			wr(`UBPC_CTL1_ADDR + 8'(2 * k), 16'h0001);
		end
		repeat (2) @(posedge core_clk);
		#1;
		chk(16'(ready_irq_dma), 16'h0001);
		buf_cpu_ok <= 4'b0001;
		wr(`UBPC_CTL1_ADDR, 16'hFFFF);
		rchk(`UBPC_CTL1_ADDR, 16'h8213);
		chk(16'(buffer_flush_ctl), 16'h0001);
		// Pipe 1 OUT handshake table
		for (k = 0; k < 9; k++) begin
			wr(`UBPC_CTL1_ADDR, hctl[k]);
			hs_mode <= hsm[k];
			rx_space_2x <= spc[k];
			rx_buf_full <= ful[k];
			ubpc_host_model_inst.token(3'h1, v, c);
			chk({12'h000, v, c}, {12'h001, hexp[k]});
			chk(16'(hs_discard), 16'(dsc[k]));
		end
		wr(`UBPC_CTL2_ADDR, 16'h0001);
		tx_buf_rdy <= 1'b1;
		ubpc_host_model_inst.token(3'h2, v, c);
		chk({12'h000, v, c}, {12'h001, 3'h4});
		ubpc_host_model_inst.token(3'h5, v, c);
		chk(16'(v), 16'h0000);
		// Toggles: software reset, hardware advance, bus reset
		@(posedge core_clk);
		tog_adv <= 4'h1;
		@(posedge core_clk);
		tog_adv <= 4'h0;
		wr(`UBPC_CTL1_ADDR, 16'h0100);
		ubpc_host_model_inst.token(3'h1, v, c);
		chk(16'(hs_toggle), 16'h0000);
		wr(`UBPC_CTL1_ADDR, 16'h0001);
		tog_adv <= 4'h1;
		@(posedge core_clk);
		tog_adv <= 4'h0;
		usb_bus_rst <= 1'b1;
		@(posedge core_clk);
		usb_bus_rst <= 1'b0;
		rchk(`UBPC_CTL1_ADDR, 16'h8000);
		ubpc_host_model_inst.token(3'h1, v, c);
		chk({12'h000, hs_toggle, c}, {12'h001, 3'h0});
		wr(`UBPC_CTL1_ADDR, 16'h0100);
		ubpc_host_model_inst.token(3'h1, v, c);
		chk(16'(hs_toggle), 16'h0000);
		// Second pipe's toggle reset kept well apart from the first
		tog_adv <= 4'h2;
		@(posedge core_clk);
		tog_adv <= 4'h0;
		repeat (20) @(posedge core_clk);
		wr(`UBPC_CTL2_ADDR, 16'h0100);
		ubpc_host_model_inst.token(3'h2, v, c);
		chk({12'h000, hs_toggle, c}, {12'h000, 1'b0, 3'h0});
		// Transfer completion, full speed then hi-speed
		hs_mode <= 1'b0;
		pk(3'h1, 11'h040, 1'b1);
		pk(3'h1, 11'h00A, 1'b1);
		pk(3'h1, 11'h000, 1'b1);
		for (int p = 3; p <= 4; p++) begin
			for (k = 0; k < 7; k++) pk(3'(p), 11'h040, 1'b0);
			pk(3'(p), 11'h040, 1'b1);
		end
		pk(3'h4, 11'h040, 1'b0);
		pk(3'h4, 11'h005, 1'b1);
		transfer_count_target <= 16'h0002;
		pk(3'h3, 11'h040, 1'b0);
		pk(3'h3, 11'h040, 1'b1);
		hs_mode <= 1'b1;
		pk(3'h4, 11'h200, 1'b1);
		pk(3'h4, 11'h040, 1'b1);
		// Oversize OUT packet forces a stall
		hs_mode <= 1'b0;
		wr(`UBPC_CTL1_ADDR, 16'h0001);
		ubpc_host_model_inst.packet(3'h1, 11'h041);
		rchk(`UBPC_CTL1_ADDR, 16'h8003);
		// CPU writes into IN buffers
		cw(3'h2, 64, 1'b0);
		cw(3'h2, 3, 1'b1);
		cw(3'h4, 512, 1'b0);
		cw(3'h4, 10, 1'b1);
		hs_mode <= 1'b1;
		cw(3'h2, 512, 1'b0);
		print_verdict();
	end
endmodule
`default_nettype wire
